// *** verilog/hbs_boot_seq.sv ***
`timescale 1ns/1ns
// What this block does
// - Chip reset pin low holds standby: ports off, pins released, PLL stopped.
// - Configuration is cleared in standby and rebuilt after release; the flash clock idle level is kept.
// - After release: init stage resets logic, waits PLL lock, loads defaults.
// - With SPI strap, read four flash bytes at 0xFFFA and compare to 2DFU.
// - Match enables flash and runs from 0x0000; else continue to config read.
// - Without SPI strap, skip the probe and go to config read.
// - Flash reader does single or dual data, SPI mode 0 or mode 3.
// - Config read loads ROM defaults, then strap values override them.
// - Strap stage checks management pins when the SMBus setting is strapped.
// - Pull-ups on both management pins enter SoC config; otherwise OTP merge.
// - SoC config lets the SoC change settings; waits with no timeout.
// - OTP merge combines ROM, SoC and OTP data and programs the hub.
// - Configured hub idles, suspends while no VBUS and no connect request.
// - VBUS with charging enabled goes to charger detection.
// - VBUS with charging disabled goes straight to connect.
// - After charger detection, connect while VBUS high; leave when VBUS drops.
// - Normal mode runs the hub until VBUS drops or the system changes mode.
// - OTP reachable over USB only in normal, over SMBus only in SoC config.
// - Bridge requests from the host pass through untouched in normal mode only.
// - Chip reset low is standby watching only that pin; high runs boot.
module hbs_boot_seq
	import hbs_pkg::*;
(
	// Core clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Flash link clock
	input wire logic flash_clk_i,
	// Chip pins and analog status
	input wire logic chip_reset_n_i,
	input wire logic pll_lock_i,
	input wire hbs_strap_s strap_i,
	input wire logic mgmt_data_pin_i,
	input wire logic mgmt_clock_pin_i,
	input wire logic vbus_i,
	input wire logic hub_connect_i,
	// Same-clock inputs from hub logic
	input wire hbs_soc_wr_s soc_wr_i,
	input wire hbs_cfg_s otp_data_i,
	input wire logic [2:0] otp_valid_i,
	input wire logic chg_det_done_i,
	input wire logic host_enum_i,
	input wire logic mode_change_i,
	input wire hbs_bridge_s bridge_i,
	// Flash pins
	output logic spi_cs_n_o,
	output logic spi_sck_o,
	output logic spi_io0_o,
	output logic spi_io0_oe_n_o,
	input wire logic spi_io0_i,
	input wire logic spi_io1_i,
	// Status and control outputs
	output hbs_stage_e stage_o,
	output logic pll_run_o,
	output logic ports_en_o,
	output logic usb_pins_oe_n_o,
	output logic xact_abort_o,
	output logic flash_exec_o,
	output logic [15:0] exec_addr_o,
	output logic smbus_en_o,
	output logic otp_smbus_en_o,
	output logic otp_usb_en_o,
	output logic suspend_o,
	output logic charger_detect_stage_o,
	output logic usb_connect_o,
	output logic cfg_valid_o,
	output hbs_cfg_s cfg_o,
	output hbs_bridge_s bridge_o
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [1:0] rstn_s_q, lock_s_q, dat_s_q, clk_s_q, vbus_s_q, conn_s_q;
	hbs_strap_s strap_s1_q, strap_s2_q;

	always_ff @(posedge clock_i) begin
		rstn_s_q <= {rstn_s_q[0], chip_reset_n_i};
		lock_s_q <= {lock_s_q[0], pll_lock_i};
		dat_s_q <= {dat_s_q[0], mgmt_data_pin_i};
		clk_s_q <= {clk_s_q[0], mgmt_clock_pin_i};
		vbus_s_q <= {vbus_s_q[0], vbus_i};
		conn_s_q <= {conn_s_q[0], hub_connect_i};
		strap_s1_q <= strap_i;
		strap_s2_q <= strap_s1_q;
	end

	wire chip_run = rstn_s_q[1];
	wire vbus = vbus_s_q[1];

	////////////////////////////////////////////////////////////////////////////
	// Probe handshake, core side

	logic req_t_q;
	logic [2:0] done_s_q;
	logic link_match_q;
	wire probe_done = done_s_q[2] ^ done_s_q[1];

	////////////////////////////////////////////////////////////////////////////
	// Boot stage machine

	hbs_stage_e stage_q, stage_d;
	hbs_strap_s strap_q;
	hbs_cfg_s cfg_q;
	logic cfg_rd_phase_q;

	always_comb begin
		stage_d = stage_q;
		case (stage_q)
			HBS_STANDBY: begin
				if (chip_run) begin
					stage_d = HBS_INIT;
				end
			end
			HBS_INIT: begin
				if (lock_s_q[1]) begin
					stage_d = strap_s2_q.spi_mode ? HBS_SPI_PROBE : HBS_CFG_RD;
				end
			end
			HBS_SPI_PROBE: begin
				if (probe_done) begin
					stage_d = link_match_q ? HBS_FLASH_RUN : HBS_CFG_RD;
				end
			end
			HBS_FLASH_RUN: stage_d = HBS_FLASH_RUN;
			HBS_CFG_RD: begin
				if (cfg_rd_phase_q) begin
					stage_d = HBS_STRAP;
				end
			end
			HBS_STRAP: begin
				if (strap_q.smbus_select_setting && dat_s_q[1] && clk_s_q[1]) begin
					stage_d = HBS_SOC_CFG;
				end else begin
					stage_d = HBS_OTP_MERGE;
				end
			end
			HBS_SOC_CFG: begin
				if (soc_wr_i.valid && soc_wr_i.addr == HBS_SOC_DONE_REG) begin
					stage_d = HBS_OTP_MERGE;
				end
			end
			HBS_OTP_MERGE: stage_d = HBS_IDLE;
			HBS_IDLE: begin
				if (vbus && cfg_q.bc_en != 3'h0) begin
					stage_d = HBS_CHG_DET;
				end else if (vbus) begin
					stage_d = HBS_CONNECT;
				end
			end
			HBS_CHG_DET: begin
				if (!vbus) begin
					stage_d = HBS_IDLE;
				end else if (chg_det_done_i) begin
					stage_d = HBS_CONNECT;
				end
			end
			HBS_CONNECT: begin
				if (!vbus) begin
					stage_d = HBS_IDLE;
				end else if (host_enum_i) begin
					stage_d = HBS_NORMAL;
				end
			end
			HBS_NORMAL: begin
				if (!vbus || mode_change_i) begin
					stage_d = HBS_IDLE;
				end
			end
			default: stage_d = HBS_STANDBY;
		endcase
		if (!chip_run) begin
			stage_d = HBS_STANDBY;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			stage_q <= HBS_STANDBY;
		end else begin
			stage_q <= stage_d;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			strap_q <= '0;
		end else if (stage_q == HBS_INIT && lock_s_q[1]) begin
			strap_q <= strap_s2_q;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i || stage_q != HBS_CFG_RD) begin
			cfg_rd_phase_q <= 1'b0;
		end else begin
			cfg_rd_phase_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration image

	always_ff @(posedge clock_i) begin
		if (rst_i || stage_q == HBS_STANDBY || stage_q == HBS_INIT) begin
			cfg_q <= HBS_ROM_DEFAULT;
		end else if (stage_q == HBS_CFG_RD) begin
			cfg_q <= cfg_rd_phase_q ? strap_q.cfg : HBS_ROM_DEFAULT;
		end else if (stage_q == HBS_SOC_CFG && soc_wr_i.valid) begin
			case (soc_wr_i.addr)
				HBS_SOC_PORT_DIS_REG: cfg_q.port_dis <= soc_wr_i.data[5:0];
				HBS_SOC_NON_REM_REG: cfg_q.non_rem <= soc_wr_i.data[2:0];
				HBS_SOC_BC_EN_REG: cfg_q.bc_en <= soc_wr_i.data[2:0];
				default: cfg_q <= cfg_q;
			endcase
		end else if (stage_q == HBS_OTP_MERGE) begin
			if (otp_valid_i[2]) begin
				cfg_q.port_dis <= otp_data_i.port_dis;
			end
			if (otp_valid_i[1]) begin
				cfg_q.non_rem <= otp_data_i.non_rem;
			end
			if (otp_valid_i[0]) begin
				cfg_q.bc_en <= otp_data_i.bc_en;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i || stage_q == HBS_STANDBY || stage_q == HBS_INIT) begin
			cfg_valid_o <= 1'b0;
		end else if (stage_q == HBS_OTP_MERGE) begin
			cfg_valid_o <= 1'b1;
		end
	end

	assign cfg_o = cfg_q;

	////////////////////////////////////////////////////////////////////////////
	// Stage outputs

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pll_run_o <= 1'b0;
			ports_en_o <= 1'b0;
			usb_pins_oe_n_o <= 1'b1;
			xact_abort_o <= 1'b1;
			flash_exec_o <= 1'b0;
			smbus_en_o <= 1'b0;
			otp_smbus_en_o <= 1'b0;
			otp_usb_en_o <= 1'b0;
			suspend_o <= 1'b0;
			charger_detect_stage_o <= 1'b0;
			usb_connect_o <= 1'b0;
		end else begin
			pll_run_o <= stage_d != HBS_STANDBY;
			xact_abort_o <= stage_d == HBS_STANDBY;
			ports_en_o <= stage_d == HBS_CONNECT || stage_d == HBS_NORMAL;
			usb_pins_oe_n_o <= !(stage_d == HBS_CONNECT || stage_d == HBS_NORMAL);
			flash_exec_o <= stage_d == HBS_FLASH_RUN;
			smbus_en_o <= stage_d == HBS_SOC_CFG;
			otp_smbus_en_o <= stage_d == HBS_SOC_CFG;
			otp_usb_en_o <= stage_d == HBS_NORMAL;
			suspend_o <= stage_d == HBS_IDLE && !vbus_s_q[1] && !conn_s_q[1];
			charger_detect_stage_o <= stage_d == HBS_CHG_DET;
			usb_connect_o <= (stage_d == HBS_CONNECT || stage_d == HBS_NORMAL) && vbus;
		end
	end

	assign stage_o = stage_q;
	assign exec_addr_o = HBS_EXEC_ADDR;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			bridge_o <= '0;
		end else begin
			bridge_o.valid <= bridge_i.valid && stage_q == HBS_NORMAL;
			bridge_o.data <= bridge_i.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Probe handshake crossing

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			req_t_q <= 1'b0;
		end else if (stage_q == HBS_INIT && stage_d == HBS_SPI_PROBE) begin
			req_t_q <= ~req_t_q;
		end
	end

	logic done_t_q;
	logic [2:0] req_s_q;
	logic [1:0] lrst_s_q;

	always_ff @(posedge clock_i) begin
		done_s_q <= {done_s_q[1:0], done_t_q};
	end

	always_ff @(posedge flash_clk_i) begin
		req_s_q <= {req_s_q[1:0], req_t_q};
		lrst_s_q <= {lrst_s_q[0], rst_i};
	end

	wire lrst = lrst_s_q[1];
	wire lreq = req_s_q[2] ^ req_s_q[1];

	////////////////////////////////////////////////////////////////////////////
	// Flash reader, link domain

	hbs_link_e lstate_q;
	logic [6:0] cyc_q;
	logic phase_q;
	logic [31:0] sh_out_q;
	logic [31:0] sh_in_q;
	logic dual_q;
	logic cpol_q;

	wire [6:0] data_start = dual_q ? 7'(HBS_HDR_CLKS + HBS_DUMMY_CLKS) : HBS_HDR_CLKS;
	wire [6:0] last_cyc = dual_q ? 7'(data_start + HBS_DATA_CLKS_DUAL - 7'h01)
		: 7'(data_start + HBS_DATA_CLKS_SINGLE - 7'h01);

	always_ff @(posedge flash_clk_i) begin
		if (lrst) begin
			lstate_q <= HBS_L_IDLE;
			cyc_q <= 7'h00;
			phase_q <= 1'b0;
			sh_out_q <= '0;
			sh_in_q <= '0;
			dual_q <= 1'b0;
			cpol_q <= 1'b0;
			done_t_q <= 1'b0;
			link_match_q <= 1'b0;
		end else begin
			case (lstate_q)
				HBS_L_IDLE: begin
					if (lreq) begin
						// Dual mode and clock idle level
						dual_q <= strap_q.cfg.non_rem[0];
						cpol_q <= strap_q.cfg.non_rem[1];
						sh_out_q <= {strap_q.cfg.non_rem[0] ? HBS_CMD_DUAL_READ : HBS_CMD_READ,
							HBS_SIG_ADDR};
						cyc_q <= 7'h00;
						phase_q <= 1'b0;
						lstate_q <= HBS_L_XFER;
					end
				end
				HBS_L_XFER: begin
					phase_q <= ~phase_q;
					if (phase_q) begin
						if (cyc_q < HBS_HDR_CLKS) begin
							sh_out_q <= {sh_out_q[30:0], 1'b0};
						end
						if (cyc_q >= data_start) begin
							sh_in_q <= dual_q ? {sh_in_q[29:0], spi_io1_i, spi_io0_i}
								: {sh_in_q[30:0], spi_io1_i};
						end
						cyc_q <= cyc_q + 7'h01;
						if (cyc_q == last_cyc) begin
							lstate_q <= HBS_L_DONE;
						end
					end
				end
				HBS_L_DONE: begin
					link_match_q <= sh_in_q == HBS_SIGNATURE;
					done_t_q <= ~done_t_q;
					lstate_q <= HBS_L_IDLE;
				end
				default: lstate_q <= HBS_L_IDLE;
			endcase
		end
	end

	wire xfer = lstate_q == HBS_L_XFER;
	assign spi_cs_n_o = !xfer;
	assign spi_sck_o = xfer ? phase_q : cpol_q;
	assign spi_io0_o = sh_out_q[31];
	assign spi_io0_oe_n_o = !(xfer && cyc_q < HBS_HDR_CLKS);

endmodule : hbs_boot_seq

// *** inc/hbs_pkg.sv ***
package hbs_pkg;

	// Boot stages, Gray coded along the usual path
	typedef enum logic [3:0] {
		HBS_STANDBY   = 4'h0,
		HBS_INIT      = 4'h1,
		HBS_CFG_RD    = 4'h3,
		HBS_STRAP     = 4'h2,
		HBS_SOC_CFG   = 4'h6,
		HBS_OTP_MERGE = 4'h7,
		HBS_IDLE      = 4'h5,
		HBS_CHG_DET   = 4'h4,
		HBS_CONNECT   = 4'hc,
		HBS_NORMAL    = 4'hd,
		HBS_SPI_PROBE = 4'hf,
		HBS_FLASH_RUN = 4'he
	} hbs_stage_e;

	// Flash probe link states
	typedef enum logic [1:0] {
		HBS_L_IDLE = 2'h0,
		HBS_L_XFER = 2'h1,
		HBS_L_DONE = 2'h3
	} hbs_link_e;

	// Hub configuration image
	typedef struct packed {
		logic [5:0] port_dis;
		logic [2:0] non_rem;
		logic [2:0] bc_en;
	} hbs_cfg_s;

	// Sampled strap options
	typedef struct packed {
		logic spi_mode;
		logic smbus_select_setting;
		hbs_cfg_s cfg;
	} hbs_strap_s;

	// One configuration write from the management bus
	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} hbs_soc_wr_s;

	// One bridge request passed through unchanged
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} hbs_bridge_s;

	localparam hbs_cfg_s HBS_ROM_DEFAULT = '{port_dis: 6'h00, non_rem: 3'h0, bc_en: 3'h0};
	localparam logic [7:0] HBS_SOC_DONE_REG = 8'hff;
	localparam logic [7:0] HBS_SOC_PORT_DIS_REG = 8'h00;
	localparam logic [7:0] HBS_SOC_NON_REM_REG = 8'h01;
	localparam logic [7:0] HBS_SOC_BC_EN_REG = 8'h02;
	localparam logic [23:0] HBS_SIG_ADDR = 24'h00fffa;
	localparam logic [15:0] HBS_EXEC_ADDR = 16'h0000;
	localparam logic [31:0] HBS_SIGNATURE = 32'h32444655;
	localparam logic [7:0] HBS_CMD_READ = 8'h03;
	localparam logic [7:0] HBS_CMD_DUAL_READ = 8'h3b;
	localparam logic [6:0] HBS_HDR_CLKS = 7'h20;
	localparam logic [6:0] HBS_DUMMY_CLKS = 7'h08;
	localparam logic [6:0] HBS_DATA_CLKS_SINGLE = 7'h20;
	localparam logic [6:0] HBS_DATA_CLKS_DUAL = 7'h10;

endpackage : hbs_pkg

// *** test/hbs_boot_seq_monitor.sv ***
`timescale 1ns/1ns
module hbs_boot_seq_monitor
	import hbs_pkg::*;
(
	// Core clock and inputs
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic chip_reset_n_i,
	input wire hbs_soc_wr_s soc_wr_i,
	input wire hbs_bridge_s bridge_i,
	// Observed outputs
	input wire hbs_stage_e stage_o,
	input wire logic pll_run_o,
	input wire logic ports_en_o,
	input wire logic usb_pins_oe_n_o,
	input wire logic otp_smbus_en_o,
	input wire logic cfg_valid_o,
	input wire hbs_bridge_s bridge_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	wire logic soc_done = soc_wr_i.valid && soc_wr_i.addr == HBS_SOC_DONE_REG;
	////////////////////////////////////////////////////////////
	a_standby_outputs: assert property (
		$past(stage_o) == HBS_STANDBY && stage_o == HBS_STANDBY
		|-> !ports_en_o && usb_pins_oe_n_o && !pll_run_o) else $error("standby outputs on");
	a_pin_standby: assert property (!chip_reset_n_i [*5] |-> stage_o == HBS_STANDBY)
		else $error("pin low without standby");
	a_soc_exit: assert property (stage_o == HBS_SOC_CFG && soc_done
		|=> stage_o == HBS_OTP_MERGE) else $error("soc done write ignored");
	a_soc_waits: assert property (stage_o == HBS_SOC_CFG && !soc_done && chip_reset_n_i
		|=> stage_o == HBS_SOC_CFG) else $error("soc stage left early");
	a_merge_valid: assert property ($rose(cfg_valid_o) |-> $past(stage_o) == HBS_OTP_MERGE)
		else $error("config valid outside merge");
	a_otp_smbus: assert property (otp_smbus_en_o
		|-> stage_o == HBS_SOC_CFG || $past(stage_o) == HBS_SOC_CFG) else $error("otp smbus open");
	a_bridge_pass: assert property (bridge_i.valid && stage_o == HBS_NORMAL
		|=> bridge_o == $past(bridge_i)) else $error("bridge not forwarded");
	a_merge_order: assert property (stage_o == HBS_OTP_MERGE
		|-> $past(stage_o) inside {HBS_STRAP, HBS_SOC_CFG}) else $error("merge out of order");
	c_flash_run: cover property (stage_o == HBS_FLASH_RUN);
	c_soc_cfg: cover property (stage_o == HBS_SOC_CFG);
	c_normal: cover property (stage_o == HBS_NORMAL);
endmodule : hbs_boot_seq_monitor

bind hbs_boot_seq hbs_boot_seq_monitor mon (.*);

// *** test/hbs_flash_model.sv ***
`timescale 1ns/1ns
module hbs_flash_model
	import hbs_pkg::*;
(
	// Flash pins from the hub
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic io0_i,
	// Bench controls
	input wire logic dual_i,
	input wire logic [31:0] sig_i,
	// Flash data out
	output logic io0_o,
	output logic io1_o
);
	int n = 0;
	logic [31:0] hdr = '0;
	logic [31:0] dat = '0;
	initial begin
		io0_o = 1'b0;
		io1_o = 1'b1;
	end
	always @(negedge cs_n_i) begin
		n = 0;
		dat = sig_i;
	end
	always @(posedge sck_i) begin
		if (!cs_n_i) begin
			if (n < 32) hdr = {hdr[30:0], io0_i};
			n = n + 1;
		end
	end
	// data out, wrong header reads garbage
	always @(negedge sck_i) begin
		if (!cs_n_i && n >= (dual_i ? 40 : 32)) begin
			if (n == (dual_i ? 40 : 32) &&
				hdr !== {(dual_i ? HBS_CMD_DUAL_READ : HBS_CMD_READ), HBS_SIG_ADDR}) dat = ~dat;
			if (dual_i) begin
				{io1_o, io0_o} = dat[31:30];
				dat = dat << 2;
			end else begin
				io1_o = dat[31];
				dat = dat << 1;
			end
		end
	end
	// Released lines do not keep the last value
	always @(posedge cs_n_i) begin
		io0_o = ~io0_o;
		io1_o = ~io1_o;
	end
endmodule : hbs_flash_model

// *** test/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
	import hbs_pkg::*;
	logic clock_i = 1'b0;
	logic flash_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic pin_n = 1'b0;
	logic lock = 1'b0;
	logic vbus = 1'b0;
	logic mgmt = 1'b0;
	logic mgmt_c = 1'b0;
	logic hub_conn = 1'b0;
	logic chg_done = 1'b0;
	logic host_enum = 1'b0;
	logic mode_chg = 1'b0;
	logic cs_seen = 1'b0;
	logic soc_seen = 1'b0;
	logic [2:0] otp_v = 3'h0;
	logic [31:0] sig = HBS_SIGNATURE;
	hbs_strap_s strap = '0;
	hbs_cfg_s otp_d = '0;
	hbs_soc_wr_s soc_wr = '0;
	hbs_bridge_s brg = '0;
	logic cs_n, sck, io0, io0_oe_n, m_io0, m_io1, pll_run, ports_en, usb_oe_n, abort_o, fexec;
	logic otp_smb, otp_usb, susp, chg_stage, conn, cfg_valid;
	logic smb_en;
	logic [15:0] exec_a;
	hbs_stage_e stage;
	hbs_cfg_s cfg;
	hbs_bridge_s brg_o;
	wire logic io0_w;
	int checks = 0;
	int n_fail = 0;
	assign io0_w = io0_oe_n ? m_io0 : io0;
	always #4 clock_i = ~clock_i;
	initial begin
		#5;
		forever #16 flash_clk_i = ~flash_clk_i;
	end
	always @(negedge cs_n) cs_seen = 1'b1;
	always @(posedge clock_i) if (stage === HBS_SOC_CFG) soc_seen <= 1'b1;
	////////////////////////////////////////////////////////////
	hbs_boot_seq dut (.clock_i(clock_i), .rst_i(rst_i), .flash_clk_i(flash_clk_i),
		.chip_reset_n_i(pin_n), .pll_lock_i(lock), .strap_i(strap), .mgmt_data_pin_i(mgmt),
		.mgmt_clock_pin_i(mgmt_c), .vbus_i(vbus), .hub_connect_i(hub_conn), .soc_wr_i(soc_wr),
		.otp_data_i(otp_d), .otp_valid_i(otp_v), .chg_det_done_i(chg_done),
		.host_enum_i(host_enum), .mode_change_i(mode_chg), .bridge_i(brg), .spi_cs_n_o(cs_n),
		.spi_sck_o(sck), .spi_io0_o(io0), .spi_io0_oe_n_o(io0_oe_n), .spi_io0_i(io0_w),
		.spi_io1_i(m_io1), .stage_o(stage), .pll_run_o(pll_run), .ports_en_o(ports_en),
		.usb_pins_oe_n_o(usb_oe_n), .xact_abort_o(abort_o), .flash_exec_o(fexec),
		.exec_addr_o(exec_a), .smbus_en_o(smb_en), .otp_smbus_en_o(otp_smb),
		.otp_usb_en_o(otp_usb),
		.suspend_o(susp), .charger_detect_stage_o(chg_stage), .usb_connect_o(conn),
		.cfg_valid_o(cfg_valid), .cfg_o(cfg), .bridge_o(brg_o));
	hbs_flash_model flash (.cs_n_i(cs_n), .sck_i(sck), .io0_i(io0_w),
		.dual_i(strap.cfg.non_rem[0]), .sig_i(sig), .io0_o(m_io0), .io1_o(m_io1));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : cyc
	task automatic wait_stage(input hbs_stage_e s);
		int i;
		i = 0;
		while (stage !== s && i < 3000) begin
			cyc(1);
			i++;
		end
		chk(stage, s);
	endtask : wait_stage
	task automatic soc_write(input logic [7:0] a, input logic [7:0] d);
		soc_wr = '{1'b1, a, d};
		cyc(1);
		soc_wr = '0;
		cyc(1);
	endtask : soc_write
	task automatic boot(input hbs_strap_s s);
		pin_n = 1'b0;
		lock = 1'b0;
		vbus = 1'b0;
		cyc(8);
		chk(stage, HBS_STANDBY);
		chk({ports_en, usb_oe_n, pll_run, abort_o}, 4'h5);
		strap = s;
		cs_seen = 1'b0;
		soc_seen = 1'b0;
		pin_n = 1'b1;
		cyc(10);
		chk(stage, HBS_INIT);
		lock = 1'b1;
	endtask : boot
	////////////////////////////////////////////////////////////
	task automatic t_spi;
		logic [2:0] nr [3];
		nr = '{3'h0, 3'h3, 3'h1};
		mgmt = 1'b1;
		mgmt_c = 1'b1;
		for (int k = 0; k < 3; k++) begin
			sig = (k == 2) ? ~HBS_SIGNATURE : HBS_SIGNATURE;
			boot('{1'b1, 1'b0, '{6'h00, nr[k], 3'h0}});
			if (k < 2) begin
				wait_stage(HBS_FLASH_RUN);
				cyc(2);
				chk(fexec, 1'b1);
				chk(exec_a, HBS_EXEC_ADDR);
			end else begin
				wait_stage(HBS_IDLE);
				chk(fexec, 1'b0);
				chk(soc_seen, 1'b0);
			end
			chk({cs_seen, cs_n, sck}, {2'h3, nr[k][1]});
		end
	endtask : t_spi
	task automatic t_soc;
		mgmt = 1'b1;
		mgmt_c = 1'b1;
		boot('{1'b0, 1'b1, '{6'h03, 3'h2, 3'h4}});
		wait_stage(HBS_SOC_CFG);
		cyc(2);
		chk(otp_smb, 1'b1);
		chk(smb_en, 1'b1);
		soc_write(8'h00, 8'h15);
		cyc(200);
		chk(stage, HBS_SOC_CFG);
		otp_d = '{6'h00, 3'h0, 3'h6};
		otp_v = 3'h1;
		soc_write(HBS_SOC_DONE_REG, 8'h00);
		wait_stage(HBS_IDLE);
		cyc(1);
		chk({cfg_valid, cfg}, {1'b1, 6'h15, 3'h2, 3'h6});
		vbus = 1'b1;
		wait_stage(HBS_CHG_DET);
		cyc(2);
		chk(chg_stage, 1'b1);
		chg_done = 1'b1;
		wait_stage(HBS_CONNECT);
		chg_done = 1'b0;
		cyc(2);
		chk(conn, 1'b1);
		vbus = 1'b0;
		wait_stage(HBS_IDLE);
		otp_v = 3'h0;
		mgmt = 1'b0;
		mgmt_c = 1'b0;
	endtask : t_soc
	task automatic t_plain;
		mgmt = 1'b1;
		boot('{1'b0, 1'b1, '{6'h2a, 3'h5, 3'h0}});
		wait_stage(HBS_IDLE);
		cyc(4);
		chk({soc_seen, cs_seen, susp}, 3'h1);
		chk(cfg, {6'h2a, 3'h5, 3'h0});
		hub_conn = 1'b1;
		cyc(4);
		chk(susp, 1'b0);
		hub_conn = 1'b0;
		vbus = 1'b1;
		wait_stage(HBS_CONNECT);
		host_enum = 1'b1;
		wait_stage(HBS_NORMAL);
		host_enum = 1'b0;
		cyc(2);
		chk(otp_usb, 1'b1);
		brg = '{1'b1, 8'ha5};
		cyc(1);
		brg = '0;
		chk(brg_o, {1'b1, 8'ha5});
		mode_chg = 1'b1;
		wait_stage(HBS_IDLE);
		mode_chg = 1'b0;
		mgmt = 1'b0;
	endtask : t_plain
	////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		cyc(16);
		rst_i = 1'b0;
		t_spi;
		t_soc;
		t_plain;
		complete_run;
	end
	initial begin
		#200000;
		n_fail++;
		complete_run;
	end
endmodule : tb_top
